/* hw/uifc_defs.vh */
`ifndef UIFC_DEFS_VH
`define UIFC_DEFS_VH
// register byte offsets on the apb slave
`define UIFC_OFF_IER 8'h00
`define UIFC_OFF_ISR 8'h04
`define UIFC_OFF_FCR 8'h08
`define UIFC_OFF_LSR 8'h0C
`define UIFC_OFF_MSR 8'h10
`define UIFC_OFF_EFR 8'h14
`define UIFC_OFF_EXTENDED_MODEM_STATUS 8'h18
`define UIFC_OFF_EVT 8'h1C
// field positions
`define UIFC_EFR_ENH 4
`define UIFC_EFR_ARTS 6
`define UIFC_EFR_ACTS 7
`define UIFC_EXTENDED_MODEM_STATUS_IMMERR 6
`define UIFC_FCR_EN 0
`define UIFC_FCR_RXRST 1
`define UIFC_FCR_TXRST 2
`define UIFC_FCR_DMA 3
// reset values
`define UIFC_IER_RST 8'h00
`define UIFC_FCR_RST 8'h00
`define UIFC_EFR_RST 8'h00
`define UIFC_EXTENDED_MODEM_STATUS_RST 8'h00
// interrupt status codes, bits 5..0
`define UIFC_ID_LS 6'h06
`define UIFC_ID_TO 6'h0C
`define UIFC_ID_RX 6'h04
`define UIFC_ID_TX 6'h02
`define UIFC_ID_MS 6'h00
`define UIFC_ID_XOFF 6'h10
`define UIFC_ID_FLOW 6'h20
`define UIFC_ID_NONE 6'h01
// receive timeout: 4 chars plus 12 bits, in bit times
`define UIFC_TO_CHARS 4
`define UIFC_TO_BITS 12
`endif

/* hw/uifc_edge.v */
`timescale 1ns/100ps
`default_nettype none
// rising-edge detector, one-cycle pulse, gated by an enable level
module uifc_edge (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // level in, pulse out
  input wire level_in,
  input wire gate,
  output wire rise
);
  reg last_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_reg <= 1'b0;
    end else begin
      last_reg <= level_in;
    end
  end
  assign rise = gate & level_in & ~last_reg;
endmodule // uifc_edge
`default_nettype wire

/* hw/uifc_timeout.v */
`timescale 1ns/100ps
`default_nettype none
`include "uifc_defs.vh"
// receive timeout timer, counts bit ticks since last rx activity
module uifc_timeout #(
  parameter CHARS = `UIFC_TO_CHARS,
  parameter BITS = `UIFC_TO_BITS,
  parameter CW = 8
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // timing inputs
  input wire bit_tick,
  input wire [3:0] char_bits,
  input wire restart,
  input wire armed,
  output wire expired
);
  reg [CW-1:0] cnt_reg;
  wire [CW-1:0] limit;
  assign limit = CHARS[CW-1:0] * {{(CW-4){1'b0}}, char_bits} + BITS[CW-1:0];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= {CW{1'b0}};
    end else if (restart || !armed) begin
      cnt_reg <= {CW{1'b0}};
    end else if (bit_tick && cnt_reg != limit) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
  // holds until restart so the interrupt stays until serviced
  assign expired = armed && (cnt_reg == limit);
endmodule // uifc_timeout
`default_nettype wire

/* hw/uifc_top.v */
`timescale 1ns/100ps
`default_nettype none
`include "uifc_defs.vh"
module uifc_top #(
  parameter TO_W = 8
) (
  // apb
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // receive side status
  input wire rx_data_present,
  input wire rx_at_trigger,
  input wire rx_overrun,
  input wire [2:0] rx_head_errors,
  input wire rx_fifo_error,
  input wire rx_char_stored,
  input wire rx_head_pop,
  input wire bit_tick,
  input wire [3:0] char_bits,
  // transmit side status
  input wire tx_holding_empty,
  input wire tx_below_trigger,
  input wire tx_all_empty,
  input wire rs485_auto,
  // modem and flow control
  input wire [3:0] modem_delta,
  input wire rts_level,
  input wire cts_level,
  input wire xoff_match,
  input wire xon_match,
  // block outputs
  output reg irq,
  output reg fifo_enable,
  output reg rx_fifo_reset,
  output reg tx_fifo_reset,
  output reg dma_mode,
  output reg sleep_enable,
  output reg polled_mode,
  output reg [7:0] line_status
);
////////////////////////////////////////////////////////////////////////
  reg [7:0] ier_reg;
  reg [7:0] efr_reg;
  reg [7:0] extended_modem_status_reg;
  reg [5:0] latched_id_reg;
  reg ls_pend_reg;
  reg tx_pend_reg;
  reg ms_pend_reg;
  reg xoff_pend_reg;
  reg flow_pend_reg;
  reg tx_empty_last_reg;
  reg [31:0] rdata_next;
  reg [5:0] id_next;
  wire wr_acc;
  wire rd_acc;
  wire setup;
  wire enh;
  wire fifo_on;
  wire rd_isr;
  wire rd_lsr;
  wire rd_msr;
  wire wr_thr;
  wire rts_rise;
  wire cts_rise;
  wire to_expired;
  wire err_event;
  wire tx_source;
  wire tx_rise;
  wire rx_pend;
  wire to_pend;
  wire [7:0] lsr_now;
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pready & pwrite;
  assign rd_acc = psel & penable & pready & ~pwrite;
  assign enh = efr_reg[`UIFC_EFR_ENH];
  assign fifo_on = fifo_enable;
  // reads of the receive holding arrive as the rx_head_pop side-band strobe from the datapath;
  // writes to the transmit holding are decoded here from the event reg
  assign rd_isr = rd_acc && paddr == `UIFC_OFF_ISR;
  assign rd_lsr = rd_acc && paddr == `UIFC_OFF_LSR;
  assign rd_msr = rd_acc && paddr == `UIFC_OFF_MSR;
  assign wr_thr = wr_acc && paddr == `UIFC_OFF_EVT && pwdata[0];
////////////////////////////////////////////////////////////////////////
  // polled line status bits
  assign lsr_now = {rx_fifo_error, tx_all_empty, tx_holding_empty,
    rx_head_errors, rx_overrun, rx_data_present};
  // priority encoder used for both read data and interrupt output
  function [5:0] pick_id;
    input ls, to, rx, tx, ms, xo, fl;
    begin
      if (ls) pick_id = `UIFC_ID_LS;
      else if (to) pick_id = `UIFC_ID_TO;
      else if (rx) pick_id = `UIFC_ID_RX;
      else if (tx) pick_id = `UIFC_ID_TX;
      else if (ms) pick_id = `UIFC_ID_MS;
      else if (xo) pick_id = `UIFC_ID_XOFF;
      else if (fl) pick_id = `UIFC_ID_FLOW;
      else pick_id = `UIFC_ID_NONE;
    end
  endfunction
////////////////////////////////////////////////////////////////////////
  // rts rising under auto rts
  uifc_edge u_rts (
    .pclk(pclk),
    .presetn(presetn),
    .level_in(rts_level),
    .gate(efr_reg[`UIFC_EFR_ARTS]),
    .rise(rts_rise)
  );
  uifc_edge u_cts (
    .pclk(pclk),
    .presetn(presetn),
    .level_in(cts_level),
    .gate(efr_reg[`UIFC_EFR_ACTS]),
    .rise(cts_rise)
  );
  uifc_timeout #(
    .CHARS(`UIFC_TO_CHARS),
    .BITS(`UIFC_TO_BITS),
    .CW(TO_W)
  ) u_to (
    .pclk(pclk),
    .presetn(presetn),
    .bit_tick(bit_tick),
    .char_bits(char_bits),
    .restart(rx_char_stored | rx_head_pop),
    .armed(fifo_on & rx_data_present),
    .expired(to_expired)
  );
////////////////////////////////////////////////////////////////////////
  // errors at readout unless immediate mode selected
  assign err_event = rx_overrun |
    ((extended_modem_status_reg[`UIFC_EXTENDED_MODEM_STATUS_IMMERR] ? rx_char_stored : rx_head_pop) &
    (|rx_head_errors));
  // transmit source depends on fifo and rs485 mode
  assign tx_source = rs485_auto ? tx_all_empty :
    (fifo_on ? (tx_below_trigger | tx_all_empty) : tx_holding_empty);
  assign tx_rise = tx_source & ~tx_empty_last_reg;
  // receive source, level based so it holds until drained
  assign rx_pend = ier_reg[0] &
    (fifo_on ? rx_at_trigger : rx_data_present);
  // head read restarts timer and clears this
  assign to_pend = ier_reg[0] & to_expired;
  always @* begin
    id_next = pick_id(ls_pend_reg, to_pend, rx_pend, tx_pend_reg,
      ms_pend_reg, xoff_pend_reg & enh, flow_pend_reg & enh);
  end
////////////////////////////////////////////////////////////////////////
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ls_pend_reg <= 1'b0;
      tx_pend_reg <= 1'b0;
      ms_pend_reg <= 1'b0;
      xoff_pend_reg <= 1'b0;
      flow_pend_reg <= 1'b0;
      tx_empty_last_reg <= 1'b0;
    end else begin
      tx_empty_last_reg <= tx_source;
      // line status sources; line status read clears
      if (ier_reg[2] && (err_event || (!fifo_on && |lsr_now[4:1])))
        ls_pend_reg <= 1'b1;
      else if (rd_lsr)
        ls_pend_reg <= 1'b0;
      // fires at once when enabled while empty
      // status read or holding write clears, new event wins
      if ((ier_reg[1] && tx_rise) || (wr_acc && paddr == `UIFC_OFF_IER &&
          pwdata[1] && !ier_reg[1] && tx_source))
        tx_pend_reg <= 1'b1;
      else if (!ier_reg[1] || wr_thr ||
          (rd_isr && latched_id_reg == `UIFC_ID_TX))
        tx_pend_reg <= 1'b0;
      if (ier_reg[3] && |modem_delta)
        ms_pend_reg <= 1'b1;
      else if (rd_msr)
        ms_pend_reg <= 1'b0;
      // xoff gated; held until xon, cleared by status read
      if (ier_reg[5] && xoff_match)
        xoff_pend_reg <= 1'b1;
      else if (xon_match || (rd_isr && latched_id_reg == `UIFC_ID_XOFF))
        xoff_pend_reg <= 1'b0;
      // rts cts; modem read clears flow change
      if ((ier_reg[6] && rts_rise) || (ier_reg[7] && cts_rise))
        flow_pend_reg <= 1'b1;
      else if (rd_msr)
        flow_pend_reg <= 1'b0;
    end
  end
////////////////////////////////////////////////////////////////////////
  // register writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ier_reg <= `UIFC_IER_RST;
      efr_reg <= `UIFC_EFR_RST;
      extended_modem_status_reg <= `UIFC_EXTENDED_MODEM_STATUS_RST;
      fifo_enable <= 1'b0;
      rx_fifo_reset <= 1'b0;
      tx_fifo_reset <= 1'b0;
      dma_mode <= 1'b0;
    end else begin
      rx_fifo_reset <= 1'b0;
      tx_fifo_reset <= 1'b0;
      if (wr_acc) begin
        case (paddr)
          `UIFC_OFF_IER: begin
            // upper enables guarded by enhanced bit
            ier_reg[3:0] <= pwdata[3:0];
            if (enh) ier_reg[7:4] <= pwdata[7:4];
          end
          `UIFC_OFF_FCR: begin
            fifo_enable <= pwdata[`UIFC_FCR_EN];
            // other bits only with enable in same write
            if (pwdata[`UIFC_FCR_EN]) begin
              rx_fifo_reset <= pwdata[`UIFC_FCR_RXRST];
              tx_fifo_reset <= pwdata[`UIFC_FCR_TXRST];
              dma_mode <= pwdata[`UIFC_FCR_DMA];
            end
          end
          `UIFC_OFF_EFR: efr_reg <= pwdata[7:0];
          `UIFC_OFF_EXTENDED_MODEM_STATUS: extended_modem_status_reg <= pwdata[7:0];
          default: begin
          end
        endcase
      end
    end
  end
////////////////////////////////////////////////////////////////////////
  // apb read mux
  always @* begin
    rdata_next = 32'h00000000;
    case (paddr)
      `UIFC_OFF_IER: rdata_next[7:0] = ier_reg;
      // only highest pending source; fifo status bits
      `UIFC_OFF_ISR: rdata_next[7:0] = {fifo_on, fifo_on, id_next};
      `UIFC_OFF_LSR: rdata_next[7:0] = lsr_now;
      `UIFC_OFF_MSR: rdata_next[7:0] = {2'b00, flow_pend_reg,
        xoff_pend_reg, modem_delta};
      `UIFC_OFF_EFR: rdata_next[7:0] = efr_reg;
      `UIFC_OFF_EXTENDED_MODEM_STATUS: rdata_next[7:0] = extended_modem_status_reg;
      default: rdata_next = 32'h00000000;
    endcase
  end
  // one wait state: setup, access with pready low, access with pready high
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      latched_id_reg <= `UIFC_ID_NONE;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & (paddr[1:0] != 2'b00 ||
        paddr > `UIFC_OFF_EVT || (!pwrite && paddr == `UIFC_OFF_FCR));
      if (psel && penable && !pready)
        prdata <= (paddr == `UIFC_OFF_FCR) ? 32'h00000000 : rdata_next;
      // freeze id seen by this read so the clear hits that source
      if (setup || (psel && penable && !pready))
        latched_id_reg <= id_next;
    end
  end
////////////////////////////////////////////////////////////////////////
  // registered outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
      sleep_enable <= 1'b0;
      polled_mode <= 1'b0;
      line_status <= 8'h00;
    end else begin
      irq <= ~id_next[0];
      sleep_enable <= ier_reg[4] & enh;
      polled_mode <= fifo_on & (ier_reg[3:0] == 4'h0);
      line_status <= lsr_now;
    end
  end
endmodule // uifc_top
`default_nettype wire

/* verification/uifc_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
`include "uifc_defs.vh"
module uifc_assertions (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // block outputs
  input wire logic irq,
  input wire logic fifo_enable,
  input wire logic rx_fifo_reset,
  input wire logic tx_fifo_reset,
  input wire logic dma_mode,
  input wire logic polled_mode
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic done = psel && penable && pready;
  wire logic isr_rd = done && !pwrite && paddr == `UIFC_OFF_ISR;
  wire logic fcr_off = done && pwrite && paddr == `UIFC_OFF_FCR && !pwdata[0];
  a_rx_reset_once: assert property (rx_fifo_reset |=> !rx_fifo_reset)
    else $error("rx fifo reset longer than one cycle");
  a_tx_reset_once: assert property (tx_fifo_reset |=> !tx_fifo_reset)
    else $error("tx fifo reset longer than one cycle");
  a_reset_needs_en: assert property ((rx_fifo_reset || tx_fifo_reset) |-> fifo_enable)
    else $error("fifo reset while fifos off");
  a_fcr_off_drops: assert property (fcr_off |=> (!fifo_enable && !rx_fifo_reset)[*2])
    else $error("fifo control bits taken without enable");
  a_polled_fifo: assert property (polled_mode |-> $past(fifo_enable))
    else $error("polled mode without fifos");
  a_dma_fifo: assert property ($rose(dma_mode) |-> fifo_enable)
    else $error("dma mode set without fifos");
  a_isr_pending: assert property (isr_rd |-> prdata[0] == !irq)
    else $error("status pending bit disagrees with irq");
  a_isr_fifo_bits: assert property (isr_rd |-> prdata[7:6] == {2{fifo_enable}})
    else $error("status fifo bits wrong");
  a_isr_code_legal: assert property (isr_rd |-> prdata[5:0] inside {6'h06, 6'h0C, 6'h04,
    6'h02, 6'h00, 6'h10, 6'h20, 6'h01})
    else $error("illegal status code");
endmodule // uifc_assertions
bind uifc_top uifc_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .irq(irq), .fifo_enable(fifo_enable), .rx_fifo_reset(rx_fifo_reset),
  .tx_fifo_reset(tx_fifo_reset), .dma_mode(dma_mode), .polled_mode(polled_mode));
`default_nettype wire

/* verification/uifc_host.sv */
`timescale 1ns/100ps
`default_nettype none
module uifc_host (
  // apb answer
  input wire logic pclk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  // apb request
  output var logic psel,
  output var logic penable,
  output var logic pwrite,
  output var logic [7:0] paddr,
  output var logic [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // request held until pready seen at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // uifc_host
`default_nettype wire

/* verification/uifc_top_bench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "uifc_defs.vh"
module uifc_top_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, fifo_enable;
  logic rx_fifo_reset, tx_fifo_reset, dma_mode, sleep_enable, polled_mode;
  logic [7:0] paddr, line_status;
  logic [31:0] pwdata, prdata, q;
  logic rx_data_present, rx_overrun, tx_holding_empty, cts_level;
  logic [3:0] modem_delta;
  logic rx_at_trigger, rx_fifo_error, rx_head_pop, tx_all_empty, xoff_match, xon_match;
  logic [2:0] rx_head_errors;
  int mismatches, comparisons, rxr_cnt;
  uifc_host h (.pclk(pclk), .pready(pready), .prdata(prdata), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  uifc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_data_present(rx_data_present), .rx_at_trigger(rx_at_trigger),
    .rx_overrun(rx_overrun), .rx_head_errors(rx_head_errors), .rx_fifo_error(rx_fifo_error),
    .rx_char_stored(rx_overrun), .rx_head_pop(rx_head_pop), .bit_tick(1'b0),
    .char_bits(4'h8), .tx_holding_empty(tx_holding_empty), .tx_below_trigger(1'b0),
    .tx_all_empty(tx_all_empty), .rs485_auto(1'b0), .modem_delta(modem_delta),
    .rts_level(1'b0), .cts_level(cts_level), .xoff_match(xoff_match),
    .xon_match(xon_match), .irq(irq), .fifo_enable(fifo_enable),
    .rx_fifo_reset(rx_fifo_reset), .tx_fifo_reset(tx_fifo_reset), .dma_mode(dma_mode),
    .sleep_enable(sleep_enable), .polled_mode(polled_mode), .line_status(line_status));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) if (rx_fifo_reset === 1'b1) rxr_cnt++;
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
    h.xfer(1'b0, a, 32'h0, q);
    chk(n, q, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    h.xfer(1'b1, a, d, q);
  endtask
  task automatic t_reset;
    rc(`UIFC_OFF_IER, 32'h0, "enables");
    rc(`UIFC_OFF_ISR, {26'h0, `UIFC_ID_NONE}, "status");
  endtask
  task automatic t_prio;
    wr(`UIFC_OFF_IER, 32'h0F);
    tx_holding_empty <= 1'b0;
    rc(`UIFC_OFF_ISR, {26'h0, `UIFC_ID_TX}, "tx ready");
    rc(`UIFC_OFF_ISR, {26'h0, `UIFC_ID_NONE}, "tx cleared");
    @(posedge pclk);
    rx_overrun <= 1'b1;
    rx_data_present <= 1'b1;
    modem_delta <= 4'h1;
    @(posedge pclk);
    rx_overrun <= 1'b0;
    modem_delta <= 4'h0;
    rc(`UIFC_OFF_ISR, {26'h0, `UIFC_ID_LS}, "line first");
    wr(`UIFC_OFF_IER, 32'h0F);
    rc(`UIFC_OFF_ISR, {26'h0, `UIFC_ID_LS}, "line queued");
    h.xfer(1'b0, `UIFC_OFF_LSR, 32'h0, q);
    rc(`UIFC_OFF_ISR, {26'h0, `UIFC_ID_RX}, "rx next");
    rx_data_present <= 1'b0;
    rc(`UIFC_OFF_ISR, {26'h0, `UIFC_ID_MS}, "modem next");
    h.xfer(1'b0, `UIFC_OFF_MSR, 32'h0, q);
    rc(`UIFC_OFF_ISR, {26'h0, `UIFC_ID_NONE}, "modem cleared");
    wr(`UIFC_OFF_IER, 32'h0);
  endtask
  task automatic t_fifo;
    wr(`UIFC_OFF_FCR, 32'h0E);
    @(negedge pclk);
    chk("fifo off", {fifo_enable, dma_mode}, 32'h0);
    wr(`UIFC_OFF_FCR, 32'h0B);
    // polled mode follows fifo enable one cycle later
    repeat (2) @(negedge pclk);
    chk("fifo dma", {fifo_enable, dma_mode, polled_mode}, 32'h7);
    rc(`UIFC_OFF_ISR, {24'h0, 2'b11, `UIFC_ID_NONE}, "fifo bits");
    wr(`UIFC_OFF_FCR, 32'h03);
    rc(`UIFC_OFF_IER, 32'h0, "enables");
    chk("rx resets", rxr_cnt, 32'h2);
  endtask
  task automatic t_enh;
    wr(`UIFC_OFF_IER, 32'hF0);
    rc(`UIFC_OFF_IER, 32'h0, "upper locked");
    wr(`UIFC_OFF_EFR, 32'hD0);
    wr(`UIFC_OFF_IER, 32'h90);
    rc(`UIFC_OFF_IER, 32'h90, "upper open");
    chk("sleep", sleep_enable, 32'h1);
    cts_level <= 1'b1;
    rc(`UIFC_OFF_ISR, {24'h0, 2'b11, `UIFC_ID_FLOW}, "cts rise");
    h.xfer(1'b0, `UIFC_OFF_MSR, 32'h0, q);
    rc(`UIFC_OFF_ISR, {24'h0, 2'b11, `UIFC_ID_NONE}, "flow cleared");
  endtask
  task automatic t_err;
    wr(`UIFC_OFF_IER, 32'h24);
    xoff_match <= 1'b1;
    @(posedge pclk);
    xoff_match <= 1'b0;
    rc(`UIFC_OFF_ISR, {24'h0, 2'b11, `UIFC_ID_XOFF}, "xoff");
    rc(`UIFC_OFF_ISR, {24'h0, 2'b11, `UIFC_ID_NONE}, "xoff cleared");
    rx_head_errors <= 3'h2;
    rc(`UIFC_OFF_ISR, {24'h0, 2'b11, `UIFC_ID_NONE}, "error not yet read");
    chk("line status", line_status, 32'h08);
    rx_head_pop <= 1'b1;
    @(posedge pclk);
    rx_head_pop <= 1'b0;
    rc(`UIFC_OFF_ISR, {24'h0, 2'b11, `UIFC_ID_LS}, "error at readout");
    h.xfer(1'b0, `UIFC_OFF_LSR, 32'h0, q);
    rx_head_errors <= 3'h0;
    rc(`UIFC_OFF_ISR, {24'h0, 2'b11, `UIFC_ID_NONE}, "line cleared");
  endtask
  task automatic wrap_up;
    if (mismatches == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    wrap_up();
  end
  initial begin
    presetn = 1'b0;
    {rx_data_present, rx_overrun, cts_level, modem_delta} = '0;
    {rx_at_trigger, rx_fifo_error, rx_head_pop, tx_all_empty, xoff_match, xon_match} = '0;
    rx_head_errors = 3'h0;
    tx_holding_empty = 1'b1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_prio();
    t_fifo();
    t_enh();
    t_err();
    wrap_up();
  end
endmodule // uifc_top_bench
`default_nettype wire
